// file: io_pin_partner.sv
// External pins: pull-ups plus an optional outside driver
`timescale 1ns/100ps
`default_nettype none
module io_pin_partner #(
    parameter int unsigned N = 40
) (
    input  wire logic [N-1:0] pin_out,
    input  wire logic [N-1:0] pin_oe,
    input  wire logic [N-1:0] ext_val,
    input  wire logic [N-1:0] ext_drv,
    output var  logic [N-1:0] pin_in
);
    ////////////////////////////////////////////////////////////////////////////////
    // Device wins when driving; a released line takes the outside driver, else the pull-up level
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_drv[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule : io_pin_partner
`default_nettype wire

// file: io_port_pad_control.sv
// General purpose I/O ports with APB register access and pad options
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// (R1) Each port: direction, pin-level, driven-value registers
// (R2) Up to five ports, count is a parameter
// (R3) Direction 1 floats pin, 0 drives latch
// (R4) Pin-level read gives pins, write loads latch
// (R5) Pin-level read shows real pins, any direction
// (R6) Driven-value read returns latch, not pins
// (R7) Enabled peripheral takes over its pin
// (R8) Software drives pulled-up line via direction bit
// (R9) Open-drain only on serial, SPI, capture pins
// (R10) Open-drain only while unit's control bit set
// (R11) Open-drain high releases pin to pull-up
// (R12) Capture/compare register: bit1 unit2, bit0 unit1
// (R13) Transceiver register: bit1 unit2, bit0 unit1
// (R14) SPI register: bit1 unit2, bit0 unit1
// (R15) Open-drain bits 7..2 ignore writes, read zero
// (R16) TTL select moves parallel master inputs to TTL
// (R17) TTL select at pad bit 0, resets 0
// (R18) Pin inputs pass a two-stage synchroniser
module io_port_pad_control
    import io_port_pkg::*;
#(
    parameter int unsigned NUM_PORTS = MAX_PORTS,
    // Pins carrying each unit's data and clock outputs, one mask per group
    parameter logic [io_port_pkg::OD_GROUPS-1:0][io_port_pkg::MAX_PORTS*8-1:0] OD_PIN_MAP = {
        40'h00_0000_0300,   // Capture/compare 2
        40'h00_0000_0C00,   // Capture/compare 1
        40'h00_0000_00C0,   // Transceiver 2
        40'h00_00C0_0000,   // Transceiver 1
        40'h00_0300_0000,   // SPI 2
        40'h00_0028_0000    // SPI 1
    }
) (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [io_port_pkg::ADDR_WIDTH-1:0]     paddr,
    input  wire logic [io_port_pkg::DATA_WIDTH-1:0]     pwdata,
    input  wire logic [3:0]                             pstrb,
    output var  logic                                   pready,
    output var  logic [io_port_pkg::DATA_WIDTH-1:0]     prdata,
    output var  logic                                   pslverr,
    input  wire logic [NUM_PORTS*io_port_pkg::PORT_WIDTH-1:0] periph_en,
    input  wire logic [NUM_PORTS*io_port_pkg::PORT_WIDTH-1:0] periph_out,
    input  wire logic [NUM_PORTS*io_port_pkg::PORT_WIDTH-1:0] periph_oe,
    input  wire logic [NUM_PORTS*io_port_pkg::PORT_WIDTH-1:0] pin_in,
    output var  logic [NUM_PORTS*io_port_pkg::PORT_WIDTH-1:0] pin_out,
    output var  logic [NUM_PORTS*io_port_pkg::PORT_WIDTH-1:0] pin_oe,
    output var  logic                                   parallel_master_ttl_select
);

    localparam int unsigned PINS = NUM_PORTS * PORT_WIDTH;  // Total pins

    // Open-drain control fields, only two bits each are implemented
    logic [OD_FIELD_WIDTH-1:0] spi_open_drain_control_r;
    logic [OD_FIELD_WIDTH-1:0] uart_open_drain_control_r;
    logic [OD_FIELD_WIDTH-1:0] capcomp_open_drain_control_r;
    logic [OD_GROUPS-1:0]      od_group;          // Enable per unit
    logic [PINS-1:0]           od_pin;            // Enable per pin
    // Slice state views
    logic [PINS-1:0]           dir_all;
    logic [PINS-1:0]           driven_all;
    logic [PINS-1:0]           level_all;
    // Bus decode
    logic                      commit;            // Access completing this edge
    logic [11:0]               reg_index;         // Word index of the address
    logic [11:0]               port_sel;          // Port number field
    logic [3:0]                port_off;          // Offset inside a port block
    logic                      port_hit;          // Address lands in a port block
    logic                      lane0;             // Low byte lane written
    logic [DATA_WIDTH-1:0]     rdata_nxt;
    logic                      err_nxt;
    logic [NUM_PORTS-1:0]      dir_we;
    logic [NUM_PORTS-1:0]      driven_we;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    assign commit    = psel & penable & pready;
    assign reg_index = (paddr[15:14] == 2'h0) ? paddr[13:2] : 12'h000;
    assign port_sel  = paddr[15:4];
    assign port_off  = paddr[3:0];
    assign lane0     = pstrb[0];
    // Ports sit at the bottom of the map, four words each, the last unused
    assign port_hit  = (port_sel < 12'(NUM_PORTS)) && (port_off != 4'hC)
                       && (paddr[1:0] == 2'h0);

    // Write strobes into each port slice
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            dir_we[p]    = commit & pwrite & lane0 & port_hit
                           & (port_sel == 12'(p)) & (port_off == DIR_OFFSET);
            // Both the pin-level and the driven-value words load the latch
            driven_we[p] = commit & pwrite & lane0 & port_hit
                           & (port_sel == 12'(p))
                           & ((port_off == LEVEL_OFFSET)                 // [R4]
                              | (port_off == DRIVEN_OFFSET));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One slice per port present
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port                // [R1] [R2]
        io_port_slice #(
            .W            (PORT_WIDTH)
        ) u_slice (
            .pclk         (pclk),
            .presetn      (presetn),
            .dir_we       (dir_we[p]),
            .driven_we    (driven_we[p]),
            .wdata        (pwdata[PORT_WIDTH-1:0]),
            .periph_en    (periph_en[p*PORT_WIDTH +: PORT_WIDTH]),
            .periph_out   (periph_out[p*PORT_WIDTH +: PORT_WIDTH]),
            .periph_oe    (periph_oe[p*PORT_WIDTH +: PORT_WIDTH]),
            .od_en        (od_pin[p*PORT_WIDTH +: PORT_WIDTH]),
            .pin_in       (pin_in[p*PORT_WIDTH +: PORT_WIDTH]),
            .pin_out      (pin_out[p*PORT_WIDTH +: PORT_WIDTH]),
            .pin_oe       (pin_oe[p*PORT_WIDTH +: PORT_WIDTH]),
            .direction    (dir_all[p*PORT_WIDTH +: PORT_WIDTH]),
            .driven_value (driven_all[p*PORT_WIDTH +: PORT_WIDTH]),
            .pin_level    (level_all[p*PORT_WIDTH +: PORT_WIDTH])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain control registers; upper bits have no storage at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spi_open_drain_control_r     <= OD_RESET;
            uart_open_drain_control_r    <= OD_RESET;
            capcomp_open_drain_control_r <= OD_RESET;
        end else if (commit && pwrite && lane0 && paddr[1:0] == 2'h0) begin
            if (reg_index == SPI_OD_INDEX) begin
                spi_open_drain_control_r     <= pwdata[OD_FIELD_WIDTH-1:0];  // [R14] [R15]
            end
            if (reg_index == UART_OD_INDEX) begin
                uart_open_drain_control_r    <= pwdata[OD_FIELD_WIDTH-1:0];  // [R13] [R15]
            end
            if (reg_index == CC_OD_INDEX) begin
                capcomp_open_drain_control_r <= pwdata[OD_FIELD_WIDTH-1:0];  // [R12] [R15]
            end
        end
    end

    // Pad configuration: TTL select for the parallel master inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parallel_master_ttl_select <= TTL_SEL_RESET;                  // [R17]
        end else if (commit && pwrite && lane0 && paddr[1:0] == 2'h0
                     && reg_index == PAD_CFG_INDEX) begin
            parallel_master_ttl_select <= pwdata[TTL_SEL_BIT];           // [R16] [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Unit enables spread to the pins that carry that unit's outputs
    always_comb begin
        od_group[GRP_SPI1]  = spi_open_drain_control_r[OD_UNIT1_BIT];    // [R14]
        od_group[GRP_SPI2]  = spi_open_drain_control_r[OD_UNIT2_BIT];    // [R14]
        od_group[GRP_UART1] = uart_open_drain_control_r[OD_UNIT1_BIT];   // [R13]
        od_group[GRP_UART2] = uart_open_drain_control_r[OD_UNIT2_BIT];   // [R13]
        od_group[GRP_CC1]   = capcomp_open_drain_control_r[OD_UNIT1_BIT];  // [R12]
        od_group[GRP_CC2]   = capcomp_open_drain_control_r[OD_UNIT2_BIT];  // [R12]
        od_pin = '0;
        // Pins outside every mask can never go open-drain
        for (int g = 0; g < OD_GROUPS; g++) begin
            od_pin = od_pin | (OD_PIN_MAP[g][PINS-1:0] & {PINS{od_group[g]}});  // [R9] [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and unmapped detection
    always_comb begin
        rdata_nxt = '0;
        err_nxt   = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            // Misaligned addresses are refused
            err_nxt = 1'b1;
        end else if (port_hit) begin
            unique case (port_off)
                DIR_OFFSET: begin
                    rdata_nxt[PORT_WIDTH-1:0] = dir_all[port_sel*PORT_WIDTH +: PORT_WIDTH];
                end
                LEVEL_OFFSET: begin
                    // Synchronised pins, not the latch
                    rdata_nxt[PORT_WIDTH-1:0] = level_all[port_sel*PORT_WIDTH +: PORT_WIDTH];  // [R4] [R5]
                end
                default: begin
                    // Latch value so read-modify-write keeps driven bits
                    rdata_nxt[PORT_WIDTH-1:0] = driven_all[port_sel*PORT_WIDTH +: PORT_WIDTH];  // [R6]
                end
            endcase
        end else if (reg_index == SPI_OD_INDEX) begin
            rdata_nxt[OD_FIELD_WIDTH-1:0] = spi_open_drain_control_r;    // [R15]
        end else if (reg_index == UART_OD_INDEX) begin
            rdata_nxt[OD_FIELD_WIDTH-1:0] = uart_open_drain_control_r;   // [R15]
        end else if (reg_index == CC_OD_INDEX) begin
            rdata_nxt[OD_FIELD_WIDTH-1:0] = capcomp_open_drain_control_r;  // [R15]
        end else if (reg_index == PAD_CFG_INDEX) begin
            rdata_nxt[TTL_SEL_BIT] = parallel_master_ttl_select;
        end else begin
            err_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response: one wait state, so every answer comes from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? '0 : rdata_nxt;
            pslverr <= err_nxt;
        end else begin
            // Drop after the completing edge; the error flag stands only with pready
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : io_port_pad_control

`default_nettype wire

// file: io_port_pad_control_tb_top.sv
// Register-level testbench for the I/O port block
`timescale 1ns/100ps
`default_nettype none
module io_port_pad_control_tb_top;
    import io_port_pkg::*;
    localparam int unsigned N = MAX_PORTS*PORT_WIDTH;
    localparam logic [OD_GROUPS-1:0][N-1:0] MAP = {40'h0300, 40'h0C00, 40'h00C0,
        40'h00C0_0000, 40'h0300_0000, 40'h0028_0000};      // Open-drain pin groups
    localparam logic [15:0] A_PAD = {2'b00, PAD_CFG_INDEX, 2'b00};
    localparam logic [2:0][15:0] A_OD = {{2'b00, CC_OD_INDEX, 2'b00},
        {2'b00, UART_OD_INDEX, 2'b00}, {2'b00, SPI_OD_INDEX, 2'b00}};
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0]  paddr = '0;                 // Bus address
    logic [31:0]  pwdata = '0, prdata, rd;    // Bus data and last read
    logic [3:0]   pstrb = 4'hF;
    logic         pready, pslverr, ttl, er;
    logic [N-1:0] periph_en = '0, periph_out = '0, periph_oe = '0;
    logic [N-1:0] ext_val = '0, ext_drv = '0, pin_in, pin_out, pin_oe, odu;
    int           n_fail = 0, check_count = 0;
    always #5 pclk = ~pclk;
    io_port_pad_control #(.NUM_PORTS(MAX_PORTS), .OD_PIN_MAP(MAP)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .periph_en(periph_en), .periph_out(periph_out), .periph_oe(periph_oe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .parallel_master_ttl_select(ttl));
    io_pin_partner #(.N(N)) u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_drv(ext_drv), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and exit, also used when a wait runs out
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    task automatic cmp(input string nm, input logic [N-1:0] e, input logic [N-1:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    // One bus transfer; holds everything until pready is seen
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_fail++;
            end_sim();
        end
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic rdx(input logic [15:0] a, input logic [31:0] e, input logic ee = 1'b0);
        apb(1'b0, a, 32'h0);
        cmp("prdata", N'(e), N'(rd));
        cmp("pslverr", N'(ee), N'(er));
    endtask : rdx
    // Pads settle one edge after the commit; the check waits two
    task automatic pins(input logic [N-1:0] eo, input logic [N-1:0] ee);
        repeat (2) @(posedge pclk);
        #1;
        cmp("pin_out", eo, pin_out);
        cmp("pin_oe", ee, pin_oe);
    endtask : pins
    function automatic logic [15:0] pa(input int p, input logic [3:0] off);
        return 16'(p) * PORT_STRIDE + 16'(off);
    endfunction : pa
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        odu = '0;
        for (int g = 0; g < OD_GROUPS; g++) odu |= MAP[g];
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < MAX_PORTS; p++) begin
            rdx(pa(p, DIR_OFFSET), 32'(DIR_RESET));
            rdx(pa(p, DRIVEN_OFFSET), 32'(DRIVEN_RESET));
        end
        for (int r = 0; r < 3; r++) rdx(A_OD[r], 32'h0);
        rdx(A_PAD, 32'h0);
        // Drive a value, then float the port under an outside driver
        apb(1'b1, pa(3, DRIVEN_OFFSET), 32'hA5);
        apb(1'b1, pa(3, DIR_OFFSET), 32'h0);
        pins(40'hA5 << 24, 40'hFF << 24);
        rdx(pa(3, LEVEL_OFFSET), 32'hA5);
        ext_val <= 40'h3C << 24;
        ext_drv <= 40'hFF << 24;
        apb(1'b1, pa(3, DIR_OFFSET), 32'hFF);
        pins(40'hA5 << 24, 40'h0);
        rdx(pa(3, LEVEL_OFFSET), 32'h3C);
        rdx(pa(3, DRIVEN_OFFSET), 32'hA5);
        apb(1'b1, pa(3, LEVEL_OFFSET), 32'h5A);
        rdx(pa(3, DRIVEN_OFFSET), 32'h5A);
        // Pulled-up line signalled by the direction bit alone
        apb(1'b1, pa(2, DIR_OFFSET), 32'h7F);
        repeat (4) @(posedge pclk);
        rdx(pa(2, LEVEL_OFFSET), 32'h7F);
        apb(1'b1, pa(2, DIR_OFFSET), 32'hFF);
        repeat (4) @(posedge pclk);
        rdx(pa(2, LEVEL_OFFSET), 32'hFF);
        // Peripheral takeover with every unit open-drain, then one unit off at a time
        periph_en <= '1; periph_out <= '1; periph_oe <= '1;
        for (int r = 0; r < 3; r++) apb(1'b1, A_OD[r], 32'hFF);
        for (int r = 0; r < 3; r++) rdx(A_OD[r], 32'h3);
        pins('1, ~odu);
        for (int g = 0; g < OD_GROUPS; g++) begin
            apb(1'b1, A_OD[g/2], 32'h3 ^ (32'h1 << (g % 2)));
            pins('1, ~odu | MAP[g]);
            apb(1'b1, A_OD[g/2], 32'h3);
        end
        periph_out <= '0;
        pins('0, '1);
        // Input buffer select, strobe-less write ignored
        apb(1'b1, A_PAD, 32'hFF);
        rdx(A_PAD, 32'h1);
        cmp("ttl", N'(1), N'(ttl));
        apb(1'b1, A_PAD, 32'h0);
        pstrb <= 4'h0;
        apb(1'b1, A_PAD, 32'h1);
        pstrb <= 4'hF;
        rdx(A_PAD, 32'h0);
        cmp("ttl", N'(0), N'(ttl));
        rdx(16'h000C, 32'h0, 1'b1);
        rdx(16'h0002, 32'h0, 1'b1);
        rdx(16'h7D00, 32'h0, 1'b1);
        // Reset in mid-run restores the defaults
        periph_en <= '0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        pins('0, '0);
        rdx(pa(3, DRIVEN_OFFSET), 32'(DRIVEN_RESET));
        rdx(A_OD[0], 32'h0);
        end_sim();
    end
endmodule : io_port_pad_control_tb_top
`default_nettype wire

// file: io_port_pkg.sv
// Constants shared by the general purpose I/O port block
package io_port_pkg;

    // Port geometry
    localparam int unsigned PORT_WIDTH      = 8;    // Pins per port
    localparam int unsigned MAX_PORTS       = 5;    // Largest port count the map holds
    localparam int unsigned ADDR_WIDTH      = 16;   // APB address width
    localparam int unsigned DATA_WIDTH      = 32;   // APB data width

    // Register indices of the control registers (byte address = index * 4)
    localparam logic [11:0] PAD_CFG_INDEX   = 12'hF3C;  // pad_configuration_register
    localparam logic [11:0] SPI_OD_INDEX    = 12'hF40;  // spi_open_drain_control
    localparam logic [11:0] UART_OD_INDEX   = 12'hF41;  // uart_open_drain_control
    localparam logic [11:0] CC_OD_INDEX     = 12'hF42;  // capcomp_open_drain_control

    // Per-port register block: base = port * PORT_STRIDE
    localparam logic [15:0] PORT_STRIDE     = 16'h0010;
    localparam logic [3:0]  DIR_OFFSET      = 4'h0;     // direction_register
    localparam logic [3:0]  LEVEL_OFFSET    = 4'h4;     // pin-level register
    localparam logic [3:0]  DRIVEN_OFFSET   = 4'h8;     // driven_value_register

    // Field positions inside the open-drain and pad registers
    localparam int unsigned OD_UNIT1_BIT    = 0;    // Unit 1 enable
    localparam int unsigned OD_UNIT2_BIT    = 1;    // Unit 2 enable
    localparam int unsigned OD_FIELD_WIDTH  = 2;    // Implemented bits, 7..2 read zero
    localparam int unsigned TTL_SEL_BIT     = 0;    // parallel_master_ttl_select

    // Reset values
    localparam logic [7:0]  DIR_RESET       = 8'hFF;    // All pins inputs
    localparam logic [7:0]  DRIVEN_RESET    = 8'h00;
    localparam logic [1:0]  OD_RESET        = 2'h0;
    localparam logic        TTL_SEL_RESET   = 1'b0;     // Schmitt buffers after power-on

    // Open-drain groups, one per peripheral unit
    localparam int unsigned OD_GROUPS       = 6;
    localparam int unsigned GRP_SPI1        = 0;
    localparam int unsigned GRP_SPI2        = 1;
    localparam int unsigned GRP_UART1       = 2;
    localparam int unsigned GRP_UART2       = 3;
    localparam int unsigned GRP_CC1         = 4;
    localparam int unsigned GRP_CC2         = 5;

endpackage : io_port_pkg

// file: io_port_props.sv
// Concurrent checks on the I/O port block ports
`timescale 1ns/100ps
`default_nettype none
module io_port_props
    import io_port_pkg::*;
#(
    parameter int unsigned NUM_PORTS = MAX_PORTS,
    parameter logic [OD_GROUPS-1:0][MAX_PORTS*8-1:0] OD_PIN_MAP = '0
) (
    input wire logic                              pclk,
    input wire logic                              presetn,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [ADDR_WIDTH-1:0]             paddr,
    input wire logic [DATA_WIDTH-1:0]             pwdata,
    input wire logic [3:0]                        pstrb,
    input wire logic                              pready,
    input wire logic [DATA_WIDTH-1:0]             prdata,
    input wire logic                              pslverr,
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0]   periph_en,
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0]   periph_out,
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0]   periph_oe,
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_in,
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_out,
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_oe,
    input wire logic                              parallel_master_ttl_select
);
    localparam int unsigned N = NUM_PORTS*PORT_WIDTH;
    localparam logic [15:0] A_PAD = {2'b00, PAD_CFG_INDEX, 2'b00};    // Pad config byte address
    logic [N-1:0] od_any;                                       // Pins able to go open-drain
    wire logic    wr_c = psel && penable && pready && pwrite;   // Write commit edge
    ////////////////////////////////////////////////////////////////////////////////
    // Union of all open-drain pin groups
    always_comb begin
        od_any = '0;
        for (int g = 0; g < OD_GROUPS; g++) od_any |= OD_PIN_MAP[g][N-1:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus steps
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && !pready ##1 psel && penable && pready; endsequence
    property p_wait_state; s_setup |=> s_access; endproperty
    a_wait_state: assert property (p_wait_state) else $error("bad wait state");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_misalign; (pready && paddr[1:0] != 2'h0) |-> pslverr; endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned accepted");
    property p_upper_zero; (pready && !pwrite) |-> prdata[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    // Unimplemented control bits always read back clear
    property p_od_read;
        (pready && !pwrite && paddr[15:4] == 12'h3D0) |-> prdata[7:2] == 6'h0;
    endproperty
    a_od_read: assert property (p_od_read) else $error("open-drain 7..2 set");
    property p_ttl_cause;
        $changed(parallel_master_ttl_select) |-> $past(wr_c) && $past(paddr) == A_PAD;
    endproperty
    a_ttl_cause: assert property (p_ttl_cause) else $error("ttl changed alone");
    // Peripheral data reaches its pins one edge later
    property p_periph;
        |$past(periph_en) |-> (pin_out & $past(periph_en)) == ($past(periph_out) & $past(periph_en));
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral data lost");
    property p_non_od;
        |$past(periph_en & ~od_any) |->
            ((pin_oe ^ $past(periph_oe)) & $past(periph_en) & ~od_any) == '0;
    endproperty
    a_non_od: assert property (p_non_od) else $error("open-drain on plain pin");
    // Without writes or takeover the pads hold still
    property p_pad_hold;
        ($past(periph_en) == '0 && $past(periph_en, 2) == '0 && !$past(wr_c) && !$past(wr_c, 2))
            |-> $stable(pin_oe) && $stable(pin_out);
    endproperty
    a_pad_hold: assert property (p_pad_hold) else $error("pad moved alone");
endmodule : io_port_props
bind io_port_pad_control io_port_props #(.NUM_PORTS(NUM_PORTS), .OD_PIN_MAP(OD_PIN_MAP)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .periph_en(periph_en), .periph_out(periph_out), .periph_oe(periph_oe),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .parallel_master_ttl_select(parallel_master_ttl_select));
`default_nettype wire

// file: io_port_slice.sv
// One port: direction, driven value, pin synchroniser and pad drive
`timescale 1ns/100ps
`default_nettype none

module io_port_slice
    import io_port_pkg::*;
#(
    parameter int unsigned W = PORT_WIDTH
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          dir_we,
    input  wire logic          driven_we,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [W-1:0]  periph_en,
    input  wire logic [W-1:0]  periph_out,
    input  wire logic [W-1:0]  periph_oe,
    input  wire logic [W-1:0]  od_en,
    input  wire logic [W-1:0]  pin_in,
    output var  logic [W-1:0]  pin_out,
    output var  logic [W-1:0]  pin_oe,
    output var  logic [W-1:0]  direction,
    output var  logic [W-1:0]  driven_value,
    output var  logic [W-1:0]  pin_level
);

    logic [W-1:0] sync1_r;     // First synchroniser stage, read only by the second
    logic [W-1:0] out_nxt;     // Next pad data
    logic [W-1:0] oe_nxt;      // Next pad enable

    ////////////////////////////////////////////////////////////////////////////
    // Direction register: 1 = input, 0 = output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction <= DIR_RESET[W-1:0];
        end else if (dir_we) begin
            direction <= wdata;
        end
    end

    // Output latch, loaded by either register write path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driven_value <= DRIVEN_RESET[W-1:0];
        end else if (driven_we) begin
            driven_value <= wdata;                               // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser; pin reads see the real level whatever the direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r   <= '0;
            pin_level <= '0;
        end else begin
            sync1_r   <= pin_in;                                 // [R18]
            pin_level <= sync1_r;                                // [R5] [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive selection per pin
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (periph_en[i]) begin
                // Peripheral owns the pin; latch and direction are bypassed
                out_nxt[i] = periph_out[i];                      // [R7]
                // Open-drain: a high is released, the pull-up makes the level
                oe_nxt[i]  = periph_oe[i] & ~(od_en[i] & periph_out[i]);  // [R10] [R11]
            end else begin
                // Plain port pin: direction 0 drives latch, 1 floats
                out_nxt[i] = driven_value[i];                    // [R3]
                oe_nxt[i]  = ~direction[i];                      // [R3]
            end
        end
    end

    // Registered pad outputs so the pins change cleanly on the clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= out_nxt;
            pin_oe  <= oe_nxt;
        end
    end

endmodule : io_port_slice

`default_nettype wire
